// file: rtl/rgdm_gpio.sv
// Summary of operation
// - Bit 7 picks open-drain or push-pull; bit 5 picks input or output direction.
// - Bit 4 is read-only and returns the sampled level of the pin.
// - Pin B bit 6: edge or level trigger; level mode mirrors pin B on interrupt pin.
// - Codes Dh and Eh force either pin statically high or low.
// - Pin B code 0h shows remote wake received before resume start.
// - Pin B code 1h shows host-side forwarding of a LS/FS disconnect.
// - Pin B code 2h shows unsquelched HS traffic in L0 or chirp in reset.
// - Pin B code 3h shows ESE1 transmission after a HS disconnect.
// - Pin B codes 4h, 5h, 6h show unconfigured, host and peripheral roles.
// - Pin B code 7h shows the connected state.
// - Pin B code 8h is high during bus reset, low once L0 reached.
// - Pin B code 9h shows L0, fully configured and repeating.
// - Pin B code Ah shows L1, stopped and awaiting wake or resume.
// - Pin B code Bh shows L2, stopped and awaiting wake or resume.
// - Pin B code Ch shows the test-mode message received in L0.
// - Pin B code Fh shows an over-voltage on the data lines.
`timescale 1ns/10ps
module rgdm_gpio #(
    parameter logic [6:0] I2C_ADDR = 7'h2c
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic pin_a_i,
    output logic pin_a_o,
    output logic pin_a_oe,
    input wire logic pin_b_i,
    output logic pin_b_o,
    output logic pin_b_oe,
    output logic interrupt_out_pin,
    output logic pin_b_edge_event,
    input wire logic remote_wake_state,
    input wire logic disconnect_state,
    input wire logic hs_activity_state,
    input wire logic hs_disconnect_tx_state,
    input wire logic unconfigured_state,
    input wire logic host_state,
    input wire logic peripheral_state,
    input wire logic connected_state,
    input wire logic bus_reset_state,
    input wire logic l0_state,
    input wire logic l1_state,
    input wire logic l2_state,
    input wire logic hs_test_state,
    input wire logic overvoltage_flag
);

    typedef struct packed {
        rgdm_pkg::rgdm_i2c_state_t st;
        logic [2:0] bit_cnt;
        logic byte_done;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic host_nack;
        logic sda_oe;
        logic scl_prev;
        logic sda_prev;
        logic a_drive;
        logic a_dir;
        logic [3:0] a_sel;
        logic a_level;
        logic b_drive;
        logic b_trig;
        logic b_dir;
        logic [3:0] b_sel;
        logic b_level;
        logic b_level_prev;
        logic b_edge;
        logic a_o;
        logic a_oe;
        logic b_o;
        logic b_oe;
        logic irq_level;
    } rgdm_state_t;

    localparam rgdm_state_t STATE_RESET = '0;

    rgdm_state_t s_r;
    rgdm_state_t s_nxt;
    logic [3:0] sync_q;
    logic scl;
    logic sda;
    logic pin_a_sync;
    logic pin_b_sync;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic pin_a_val;
    logic pin_b_val;

    rgdm_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .din({pin_b_i, pin_a_i, sda_i, scl_i}),
        .dout(sync_q)
    );

    assign scl = sync_q[0];
    assign sda = sync_q[1];
    assign pin_a_sync = sync_q[2];
    assign pin_b_sync = sync_q[3];

    assign scl_rise = scl & ~s_r.scl_prev;
    assign scl_fall = ~scl & s_r.scl_prev;
    assign start_seen = scl & s_r.scl_prev & s_r.sda_prev & ~sda;
    assign stop_seen = scl & s_r.scl_prev & ~s_r.sda_prev & sda;

    // Register read image; unmapped offsets and reserved bits return zero.
    function automatic logic [7:0] read_reg(input logic [7:0] offs, input rgdm_state_t s);
        logic [7:0] d;
        d = rgdm_pkg::UNMAPPED_READ;
        if (offs == rgdm_pkg::OFFS_PIN_A_CONFIG) begin
            d[rgdm_pkg::BIT_DRIVE_TYPE] = s.a_drive;
            d[rgdm_pkg::BIT_DIR] = s.a_dir;
            d[rgdm_pkg::BIT_LEVEL] = s.a_level;
            d[rgdm_pkg::SEL_MSB:rgdm_pkg::SEL_LSB] = s.a_sel;
        end else if (offs == rgdm_pkg::OFFS_PIN_B_CONFIG) begin
            d[rgdm_pkg::BIT_DRIVE_TYPE] = s.b_drive;
            d[rgdm_pkg::BIT_IRQ_TRIGGER] = s.b_trig;
            d[rgdm_pkg::BIT_DIR] = s.b_dir;
            d[rgdm_pkg::BIT_LEVEL] = s.b_level;
            d[rgdm_pkg::SEL_MSB:rgdm_pkg::SEL_LSB] = s.b_sel;
        end
        return d;
    endfunction

    // Pin A has only the two forced levels; every other code drives low.
    always_comb begin
        case (s_r.a_sel)
            rgdm_pkg::SEL_FORCE_HIGH: pin_a_val = 1'b1;
            rgdm_pkg::SEL_FORCE_LOW: pin_a_val = 1'b0;
            default: pin_a_val = 1'b0;
        endcase
    end

    always_comb begin
        case (s_r.b_sel)
            rgdm_pkg::SEL_REMOTE_WAKE: pin_b_val = remote_wake_state;
            rgdm_pkg::SEL_DISCONNECT: pin_b_val = disconnect_state;
            rgdm_pkg::SEL_HS_ACTIVITY: pin_b_val = hs_activity_state;
            rgdm_pkg::SEL_HS_DISC_TX: pin_b_val = hs_disconnect_tx_state;
            rgdm_pkg::SEL_UNCONFIGURED: pin_b_val = unconfigured_state;
            rgdm_pkg::SEL_HOST: pin_b_val = host_state;
            rgdm_pkg::SEL_PERIPHERAL: pin_b_val = peripheral_state;
            rgdm_pkg::SEL_CONNECTED: pin_b_val = connected_state;
            rgdm_pkg::SEL_BUS_RESET: pin_b_val = bus_reset_state & ~l0_state;
            rgdm_pkg::SEL_L0: pin_b_val = l0_state;
            rgdm_pkg::SEL_L1: pin_b_val = l1_state;
            rgdm_pkg::SEL_L2: pin_b_val = l2_state;
            rgdm_pkg::SEL_HS_TEST: pin_b_val = hs_test_state;
            rgdm_pkg::SEL_FORCE_HIGH: pin_b_val = 1'b1;
            rgdm_pkg::SEL_FORCE_LOW: pin_b_val = 1'b0;
            rgdm_pkg::SEL_OVERVOLTAGE: pin_b_val = overvoltage_flag;
            default: pin_b_val = 1'b0;
        endcase
    end

    always_comb begin
        logic [7:0] rd;
        rd = rgdm_pkg::UNMAPPED_READ;
        s_nxt = s_r;
        s_nxt.scl_prev = scl;
        s_nxt.sda_prev = sda;

        // Level bits are refreshed every cycle, so a read returns the live pin.
        s_nxt.a_level = pin_a_sync;
        s_nxt.b_level = pin_b_sync;
        s_nxt.b_level_prev = s_r.b_level;
        s_nxt.b_edge = (s_r.b_trig == rgdm_pkg::TRIG_EDGE) &&
                       (s_r.b_dir == rgdm_pkg::DIR_INPUT) &&
                       (s_r.b_level != s_r.b_level_prev);
        s_nxt.irq_level = (s_r.b_trig == rgdm_pkg::TRIG_LEVEL) & s_r.b_level;

        // Open drain releases the pin for a high; push-pull drives both levels.
        s_nxt.a_o = (s_r.a_drive == rgdm_pkg::DRIVE_PUSH_PULL) & pin_a_val;
        s_nxt.a_oe = (s_r.a_dir == rgdm_pkg::DIR_OUTPUT) &&
                     ((s_r.a_drive == rgdm_pkg::DRIVE_PUSH_PULL) || !pin_a_val);
        s_nxt.b_o = (s_r.b_drive == rgdm_pkg::DRIVE_PUSH_PULL) & pin_b_val;
        s_nxt.b_oe = (s_r.b_dir == rgdm_pkg::DIR_OUTPUT) &&
                     ((s_r.b_drive == rgdm_pkg::DRIVE_PUSH_PULL) || !pin_b_val);

        if (start_seen) begin
            // A repeated start lands here too and keeps the offset pointer.
            s_nxt.st = rgdm_pkg::I2C_ADDR;
            s_nxt.bit_cnt = rgdm_pkg::BIT_CNT_FIRST;
            s_nxt.byte_done = 1'b0;
            s_nxt.sda_oe = 1'b0;
        end else if (stop_seen) begin
            s_nxt.st = rgdm_pkg::I2C_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (s_r.st)
                rgdm_pkg::I2C_ADDR, rgdm_pkg::I2C_OFFS, rgdm_pkg::I2C_WDATA: begin
                    s_nxt.shift = {s_r.shift[6:0], sda};
                    s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
                    s_nxt.byte_done = (s_r.bit_cnt == rgdm_pkg::BIT_CNT_LAST);
                end
                rgdm_pkg::I2C_RDATA: begin
                    s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
                    s_nxt.byte_done = (s_r.bit_cnt == rgdm_pkg::BIT_CNT_LAST);
                end
                rgdm_pkg::I2C_RD_ACK: begin
                    s_nxt.host_nack = sda;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (s_r.st)
                rgdm_pkg::I2C_ADDR: begin
                    if (s_r.byte_done) begin
                        s_nxt.byte_done = 1'b0;
                        if (s_r.shift[7:1] == I2C_ADDR) begin
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.host_nack = s_r.shift[0];
                            s_nxt.st = rgdm_pkg::I2C_ADDR_ACK;
                        end else begin
                            s_nxt.st = rgdm_pkg::I2C_WAIT_STOP;
                        end
                    end
                end
                rgdm_pkg::I2C_ADDR_ACK: begin
                    s_nxt.bit_cnt = rgdm_pkg::BIT_CNT_FIRST;
                    if (s_r.host_nack) begin
                        // Read: load the byte and step the pointer whether or not it is acked.
                        rd = read_reg(s_r.ptr, s_r);
                        s_nxt.shift = rd;
                        s_nxt.ptr = s_r.ptr + rgdm_pkg::PTR_STEP;
                        s_nxt.sda_oe = ~rd[7];
                        s_nxt.st = rgdm_pkg::I2C_RDATA;
                    end else begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = rgdm_pkg::I2C_OFFS;
                    end
                end
                rgdm_pkg::I2C_OFFS: begin
                    if (s_r.byte_done) begin
                        s_nxt.byte_done = 1'b0;
                        s_nxt.ptr = s_r.shift;
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st = rgdm_pkg::I2C_OFFS_ACK;
                    end
                end
                rgdm_pkg::I2C_WDATA: begin
                    if (s_r.byte_done) begin
                        s_nxt.byte_done = 1'b0;
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.ptr = s_r.ptr + rgdm_pkg::PTR_STEP;
                        s_nxt.st = rgdm_pkg::I2C_WDATA_ACK;
                        // Writes to unmapped offsets are acknowledged and dropped.
                        if (s_r.ptr == rgdm_pkg::OFFS_PIN_A_CONFIG) begin
                            s_nxt.a_drive = s_r.shift[rgdm_pkg::BIT_DRIVE_TYPE];
                            s_nxt.a_dir = s_r.shift[rgdm_pkg::BIT_DIR];
                            s_nxt.a_sel = s_r.shift[rgdm_pkg::SEL_MSB:rgdm_pkg::SEL_LSB];
                        end else if (s_r.ptr == rgdm_pkg::OFFS_PIN_B_CONFIG) begin
                            s_nxt.b_drive = s_r.shift[rgdm_pkg::BIT_DRIVE_TYPE];
                            s_nxt.b_trig = s_r.shift[rgdm_pkg::BIT_IRQ_TRIGGER];
                            s_nxt.b_dir = s_r.shift[rgdm_pkg::BIT_DIR];
                            s_nxt.b_sel = s_r.shift[rgdm_pkg::SEL_MSB:rgdm_pkg::SEL_LSB];
                        end
                    end
                end
                rgdm_pkg::I2C_OFFS_ACK, rgdm_pkg::I2C_WDATA_ACK: begin
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.bit_cnt = rgdm_pkg::BIT_CNT_FIRST;
                    s_nxt.st = rgdm_pkg::I2C_WDATA;
                end
                rgdm_pkg::I2C_RDATA: begin
                    if (s_r.byte_done) begin
                        s_nxt.byte_done = 1'b0;
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = rgdm_pkg::I2C_RD_ACK;
                    end else begin
                        s_nxt.shift = {s_r.shift[6:0], 1'b0};
                        s_nxt.sda_oe = ~s_r.shift[6];
                    end
                end
                rgdm_pkg::I2C_RD_ACK: begin
                    s_nxt.bit_cnt = rgdm_pkg::BIT_CNT_FIRST;
                    if (s_r.host_nack) begin
                        s_nxt.st = rgdm_pkg::I2C_WAIT_STOP;
                    end else begin
                        rd = read_reg(s_r.ptr, s_r);
                        s_nxt.shift = rd;
                        s_nxt.ptr = s_r.ptr + rgdm_pkg::PTR_STEP;
                        s_nxt.sda_oe = ~rd[7];
                        s_nxt.st = rgdm_pkg::I2C_RDATA;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = s_r.sda_oe;
    assign pin_a_o = s_r.a_o;
    assign pin_a_oe = s_r.a_oe;
    assign pin_b_o = s_r.b_o;
    assign pin_b_oe = s_r.b_oe;
    assign interrupt_out_pin = s_r.irq_level;
    assign pin_b_edge_event = s_r.b_edge;

endmodule

// file: rtl/rgdm_pkg.sv
package rgdm_pkg;

    // Register offsets on the I2C target port.
    localparam logic [7:0] OFFS_PIN_A_CONFIG = 8'h00;
    localparam logic [7:0] OFFS_PIN_B_CONFIG = 8'h40;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions inside a pin configuration register.
    localparam int BIT_DRIVE_TYPE = 7;
    localparam int BIT_IRQ_TRIGGER = 6;
    localparam int BIT_DIR = 5;
    localparam int BIT_LEVEL = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 0;

    // Field encodings.
    localparam logic DRIVE_OPEN_DRAIN = 1'b0;
    localparam logic DRIVE_PUSH_PULL = 1'b1;
    localparam logic DIR_INPUT = 1'b0;
    localparam logic DIR_OUTPUT = 1'b1;
    localparam logic TRIG_EDGE = 1'b0;
    localparam logic TRIG_LEVEL = 1'b1;

    // Output-select codes.
    localparam logic [3:0] SEL_REMOTE_WAKE = 4'h0;
    localparam logic [3:0] SEL_DISCONNECT = 4'h1;
    localparam logic [3:0] SEL_HS_ACTIVITY = 4'h2;
    localparam logic [3:0] SEL_HS_DISC_TX = 4'h3;
    localparam logic [3:0] SEL_UNCONFIGURED = 4'h4;
    localparam logic [3:0] SEL_HOST = 4'h5;
    localparam logic [3:0] SEL_PERIPHERAL = 4'h6;
    localparam logic [3:0] SEL_CONNECTED = 4'h7;
    localparam logic [3:0] SEL_BUS_RESET = 4'h8;
    localparam logic [3:0] SEL_L0 = 4'h9;
    localparam logic [3:0] SEL_L1 = 4'ha;
    localparam logic [3:0] SEL_L2 = 4'hb;
    localparam logic [3:0] SEL_HS_TEST = 4'hc;
    localparam logic [3:0] SEL_FORCE_HIGH = 4'hd;
    localparam logic [3:0] SEL_FORCE_LOW = 4'he;
    localparam logic [3:0] SEL_OVERVOLTAGE = 4'hf;

    // I2C framing.
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [2:0] BIT_CNT_FIRST = 3'h0;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic [7:0] PTR_RESET = 8'h00;

    typedef enum logic [3:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ADDR_ACK,
        I2C_OFFS,
        I2C_OFFS_ACK,
        I2C_WDATA,
        I2C_WDATA_ACK,
        I2C_RDATA,
        I2C_RD_ACK,
        I2C_WAIT_STOP
    } rgdm_i2c_state_t;

endpackage

// file: rtl/rgdm_sync.sv
`timescale 1ns/10ps
module rgdm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // A zero-width synchroniser would silently drop the pin, so refuse it at elaboration.
    if (WIDTH < 1) begin : g_bad_width
        $error("rgdm_sync needs WIDTH of at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } rgdm_sync_state_t;

    rgdm_sync_state_t s_r;
    rgdm_sync_state_t s_nxt;

    // The first stage feeds only the second; nothing else looks at it.
    always_comb begin
        s_nxt = s_r;
        s_nxt.stage1 = din;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.stage2;

endmodule

// file: sim/rgdm_sva.sv
`timescale 1ns/10ps
module rgdm_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic pin_a_o,
    input wire logic pin_a_oe,
    input wire logic pin_b_i,
    input wire logic interrupt_out_pin,
    input wire logic pin_b_edge_event
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_sda_open_drain: assert property (sda_o == 1'b0)
        else $error("sda data output not held low");
    a_ack_after_fall: assert property ($rose(sda_oe) |-> !scl_i && $past(scl_i, 3) == 1'b0)
        else $error("sda pulled low outside the scl low phase");
    a_ack_holds_low: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("sda pull released too early");
    a_reset_quiet: assert property ($fell(rst) |-> !sda_oe && !pin_a_oe && !pin_a_o
        && !interrupt_out_pin && !pin_b_edge_event)
        else $error("outputs not cleared by reset");
    a_level_irq_src: assert property ($rose(interrupt_out_pin) |->
        $past(pin_b_i, 3) || $past(pin_b_i, 4) || $past(pin_b_i, 5))
        else $error("interrupt pin rose without pin b high");
    a_edge_one_shot: assert property (pin_b_edge_event |=> !pin_b_edge_event)
        else $error("edge event longer than one cycle");
    a_edge_has_cause: assert property (pin_b_edge_event |-> $past(pin_b_i, 2) != $past(pin_b_i, 8))
        else $error("edge event without a pin b transition");
    a_edge_not_level: assert property (pin_b_edge_event |-> !interrupt_out_pin)
        else $error("edge event while level interrupt is high");
    a_pin_a_cfg_only: assert property ((!$stable(pin_a_o) || !$stable(pin_a_oe)) |-> !scl_i)
        else $error("pin a output changed outside a register write");

    c_ack: cover property ($rose(sda_oe));
    c_edge: cover property (pin_b_edge_event);
    c_level: cover property ($rose(interrupt_out_pin));
endmodule

bind rgdm_gpio rgdm_sva u_sva (.clk(clk), .rst(rst), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_i(pin_b_i),
    .interrupt_out_pin(interrupt_out_pin), .pin_b_edge_event(pin_b_edge_event));

// file: sim/rgdm_i2c_host.sv
`timescale 1ns/10ps
module rgdm_i2c_host #(
    parameter int HALF = 10
) (
    input wire logic clk,
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // Phases are at least five cycles, above the three-cycle delay of the synchroniser and edge detector.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Also serves as a repeated start when entered with scl low.
    task automatic start();
        sda_pull = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_pull = 1'b1;
        tick(HALF);
        scl = 1'b0;
        tick(HALF);
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_pull = 1'b0;
        tick(HALF);
    endtask

    // Data is held half a phase past the scl fall so no false start or stop is seen.
    task automatic bit_io(input logic b, output logic r);
        sda_pull = !b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF / 2);
        r = sda;
        tick(HALF / 2);
        scl = 1'b0;
        tick(HALF / 2);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, r);
    endtask
endmodule

// file: sim/rgdm_tb.sv
`timescale 1ns/10ps
module testbench;
    localparam logic [6:0] DEV = 7'h2c;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pad_a = 1'b0;
    logic pad_b = 1'b0;
    logic [13:0] st = 14'h0000;
    logic scl;
    logic h_pull;
    logic sda_oe;
    logic pa_o;
    logic pa_oe;
    logic pb_o;
    logic pb_oe;
    logic irq;
    logic evt;
    wire logic sda_line = ~(h_pull | sda_oe);
    int fails = 0;
    int checks_done = 0;

    always #2 clk = ~clk;

    rgdm_i2c_host host (.clk(clk), .scl(scl), .sda_pull(h_pull), .sda(sda_line));

    rgdm_gpio #(.I2C_ADDR(DEV)) dut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
        .sda_o(), .sda_oe(sda_oe), .pin_a_i(pa_oe ? pa_o : pad_a), .pin_a_o(pa_o),
        .pin_a_oe(pa_oe), .pin_b_i(pb_oe ? pb_o : pad_b), .pin_b_o(pb_o), .pin_b_oe(pb_oe),
        .interrupt_out_pin(irq), .pin_b_edge_event(evt), .remote_wake_state(st[0]),
        .disconnect_state(st[1]), .hs_activity_state(st[2]), .hs_disconnect_tx_state(st[3]),
        .unconfigured_state(st[4]), .host_state(st[5]), .peripheral_state(st[6]),
        .connected_state(st[7]), .bus_reset_state(st[8]), .l0_state(st[9]),
        .l1_state(st[10]), .l2_state(st[11]), .hs_test_state(st[12]),
        .overvoltage_flag(st[13]));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] offs, input logic [7:0] d);
        logic a0;
        logic a1;
        logic a2;
        host.start();
        host.wr_byte({DEV, 1'b0}, a0);
        host.wr_byte(offs, a1);
        host.wr_byte(d, a2);
        host.stop();
        chk({7'h00, a0 & a1 & a2}, 8'h01, "write acks");
        repeat (4) @(negedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] offs, output logic [7:0] d);
        logic a0;
        logic a1;
        logic a2;
        host.start();
        host.wr_byte({DEV, 1'b0}, a0);
        host.wr_byte(offs, a1);
        host.start();
        host.wr_byte({DEV, 1'b1}, a2);
        host.rd_byte(1'b1, d);
        host.stop();
        chk({7'h00, a0 & a1 & a2}, 8'h01, "read acks");
    endtask

    task automatic t_reset();
        logic [7:0] d;
        reg_rd(8'h00, d);
        chk(d, 8'h00, "pin a cfg reset");
        reg_rd(8'h40, d);
        chk(d, 8'h00, "pin b cfg reset");
    endtask

    // Columns: value written, value read back, expected {oe, o} of pin A.
    task automatic t_pin_a();
        logic [7:0] wv [5] = '{8'hfd, 8'h3d, 8'h3e, 8'hb3, 8'h10};
        logic [7:0] rv [5] = '{8'hbd, 8'h2d, 8'h2e, 8'ha3, 8'h00};
        logic [1:0] pv [5] = '{2'h3, 2'h0, 2'h2, 2'h2, 2'h0};
        logic [7:0] d;
        for (int i = 0; i < 5; i++) begin
            reg_wr(8'h00, wv[i]);
            chk({6'h00, pa_oe, pa_o}, {6'h00, pv[i]}, "pin a drive");
            reg_rd(8'h00, d);
            chk(d, rv[i], "pin a readback");
        end
    endtask

    task automatic t_pin_b_sel();
        logic [13:0] m;
        for (int c = 0; c < 16; c++) begin
            m = (c < 13) ? (14'h0001 << c) : ((c == 15) ? 14'h2000 : 14'h0000);
            reg_wr(8'h40, 8'ha0 | 8'(c));
            st = ~m;
            repeat (4) @(negedge clk);
            chk({7'h00, pb_o}, {7'h00, c == 13}, "pin b sel others");
            st = m;
            repeat (4) @(negedge clk);
            chk({6'h00, pb_oe, pb_o}, {6'h00, 1'b1, c != 14}, "pin b sel own");
        end
        reg_wr(8'h40, 8'ha8);
        st = 14'h0300;
        repeat (4) @(negedge clk);
        chk({7'h00, pb_o}, 8'h00, "reset state after l0");
        st = 14'h0000;
    endtask

    task automatic t_trigger();
        logic [7:0] d;
        int n;
        reg_wr(8'h40, 8'h40);
        pad_b = 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h00, irq}, 8'h01, "level irq high");
        reg_rd(8'h40, d);
        chk(d, 8'h50, "pin b level bit");
        pad_b = 1'b0;
        repeat (8) @(negedge clk);
        chk({7'h00, irq}, 8'h00, "level irq low");
        reg_wr(8'h40, 8'h00);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            @(negedge clk);
            pad_b = !pad_b;
            repeat (12) begin
                @(posedge clk);
                #1 n += (evt === 1'b1);
            end
            chk(8'(n), 8'h01, "edge events");
            chk({7'h00, irq}, 8'h00, "edge mode irq");
        end
    endtask

    // Offsets outside the map are only ever read, never written.
    task automatic t_refuse();
        logic [7:0] d;
        logic a;
        reg_rd(8'h20, d);
        chk(d, 8'h00, "unmapped read");
        host.start();
        host.wr_byte({DEV ^ 7'h01, 1'b0}, a);
        host.stop();
        chk({7'h00, a}, 8'h00, "foreign address nack");
    endtask

    task automatic summarize();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        t_reset();
        t_pin_a();
        t_pin_b_sel();
        t_trigger();
        t_refuse();
        summarize();
    end

    // About 27.5k cycles are expected; the 90k-cycle limit is over three times that and marks a hang.
    initial begin
        #360000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
endmodule
